// File: design/spcg_gate.sv
// Sleep-mode port clock gating register with run and deep-sleep siblings
`timescale 1ns/1ps
module spcg_gate (
	input wire logic ref_clk, // System clock, 50 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [11:0] reg_addr, // Register byte offset
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic [1:0] pwr_state, // 0 run, 1 sleep, 2/3 deep, from pins
	input wire logic port_acc, // Access to a port unit
	input wire logic [2:0] port_sel, // Port targeted by access
	output logic port_fault, // Bus fault pulse for gated access
	output logic [7:0] port_clk_en, // Per-port clock enable, A..H
	output logic irq // Level interrupt
);
	logic [7:0] sleep_reg, sleep_next;
	logic [7:0] run_reg, run_next;
	logic [7:0] deep_reg, deep_next;
	logic auto_reg, auto_next;
	logic [1:0] stat_reg, stat_next;
	logic [1:0] mask_reg, mask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic fault_reg, fault_next;
	logic [7:0] en_reg, en_next;
	logic irq_reg, irq_next;
	logic [1:0] pwr_meta_reg, pwr_sync_reg;
	logic [7:0] sel;
	spcg_pkg::spcg_pwr_e st;

	function automatic logic [31:0] pad8(input logic [7:0] v);
		pad8 = {24'h000000, v};
	endfunction

	// Power state from pins, two-stage synchroniser
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pwr_meta_reg <= 2'h0;
			pwr_sync_reg <= 2'h0;
		end else begin
			pwr_meta_reg <= pwr_state;
			pwr_sync_reg <= pwr_meta_reg;
		end
	end

	// One address compare shared by every write decode
	function automatic logic hit(input logic strobe, input logic [11:0] a,
			input logic [11:0] off);
		hit = strobe && (a == off);
	endfunction

	// Enable bit that guards one port
	function automatic logic port_on(input logic [7:0] en, input logic [2:0] p);
		case (p)
			3'h0: port_on = en[0];
			3'h1: port_on = en[1];
			3'h2: port_on = en[2];
			3'h3: port_on = en[3];
			3'h4: port_on = en[4];
			3'h5: port_on = en[5];
			3'h6: port_on = en[6];
			default: port_on = en[7];
		endcase
	endfunction

	// Codes 2 and 3 both mean deep sleep, so no state is left undecoded
	always_comb begin
		case (pwr_sync_reg)
			2'h0: begin
				st = spcg_pkg::SPCG_RUN;
			end
			2'h1: begin
				st = spcg_pkg::SPCG_SLEEP;
			end
			default: begin
				st = spcg_pkg::SPCG_DEEP;
			end
		endcase
	end

	// Gate registers: only the low byte is storage
	always_comb begin
		sleep_next = sleep_reg;
		run_next = run_reg;
		deep_next = deep_reg;
		if (hit(reg_wr, reg_addr, spcg_pkg::SLEEP_GATE_OFF)) begin
			sleep_next = reg_wdata[7:0];
		end
		if (hit(reg_wr, reg_addr, spcg_pkg::RUN_GATE_OFF)) begin
			run_next = reg_wdata[7:0];
		end
		if (hit(reg_wr, reg_addr, spcg_pkg::DEEP_GATE_OFF)) begin
			deep_next = reg_wdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sleep_reg <= spcg_pkg::GATE_RESET;
			run_reg <= spcg_pkg::GATE_RESET;
			deep_reg <= spcg_pkg::GATE_RESET;
		end else begin
			sleep_reg <= sleep_next;
			run_reg <= run_next;
			deep_reg <= deep_next;
		end
	end

	// Auto gating select: one bit of the run configuration word
	always_comb begin
		auto_next = auto_reg;
		if (hit(reg_wr, reg_addr, spcg_pkg::RUN_CFG_OFF)) begin
			auto_next = reg_wdata[spcg_pkg::AUTO_GATE_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			auto_reg <= spcg_pkg::RUN_CFG_RESET[spcg_pkg::AUTO_GATE_BIT];
		end else begin
			auto_reg <= auto_next;
		end
	end

	// Interrupt mask
	always_comb begin
		mask_next = mask_reg;
		if (hit(reg_wr, reg_addr, spcg_pkg::IRQ_MASK_OFF)) begin
			mask_next = reg_wdata[1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mask_reg <= 2'h0;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// Read mux: data stand one cycle, then fall back to zero
	always_comb begin
		rdata_next = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				spcg_pkg::SLEEP_GATE_OFF: begin
					rdata_next = pad8(sleep_reg);
				end
				spcg_pkg::RUN_GATE_OFF: begin
					rdata_next = pad8(run_reg);
				end
				spcg_pkg::DEEP_GATE_OFF: begin
					rdata_next = pad8(deep_reg);
				end
				spcg_pkg::RUN_CFG_OFF: begin
					rdata_next = 32'(auto_reg) << spcg_pkg::AUTO_GATE_BIT;
				end
				spcg_pkg::IRQ_STAT_OFF: begin
					rdata_next = {30'h0, stat_reg};
				end
				spcg_pkg::IRQ_MASK_OFF: begin
					rdata_next = {30'h0, mask_reg};
				end
				spcg_pkg::PWR_STATE_OFF: begin
					rdata_next = {29'h0, st};
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// choose register by state; sleep and deep only with auto gating
	always_comb begin
		case (st)
			spcg_pkg::SPCG_RUN: begin
				sel = run_reg;
			end
			spcg_pkg::SPCG_SLEEP: begin
				sel = auto_reg ? sleep_reg : run_reg;
			end
			spcg_pkg::SPCG_DEEP: begin
				sel = auto_reg ? deep_reg : run_reg;
			end
			default: begin
				sel = run_reg;
			end
		endcase
	end

	// enable flops change on one edge, gate cells latch them
	always_comb begin
		en_next = sel;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			en_reg <= spcg_pkg::GATE_RESET;
		end else begin
			en_reg <= en_next;
		end
	end

	always_comb begin
		fault_next = port_acc && !port_on(en_reg, port_sel);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fault_reg <= 1'b0;
		end else begin
			fault_reg <= fault_next;
		end
	end

	// Set wins over write-one-to-clear, so no event is lost to a clear
	always_comb begin
		stat_next = stat_reg;
		if (hit(reg_wr, reg_addr, spcg_pkg::IRQ_STAT_OFF)) begin
			stat_next = stat_reg & ~reg_wdata[1:0];
		end
		if (fault_next) begin
			stat_next[spcg_pkg::IRQ_FAULT_BIT] = 1'b1;
		end
		if (en_next != en_reg) begin
			stat_next[spcg_pkg::IRQ_CHANGE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stat_reg <= 2'h0;
		end else begin
			stat_reg <= stat_next;
		end
	end

	// Built from next values so the line moves with the status bit
	always_comb begin
		irq_next = |(stat_next & mask_next);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign port_fault = fault_reg;
	assign port_clk_en = en_reg;
	assign irq = irq_reg;
endmodule // spcg_gate

// File: design/spcg_pkg.sv
// Shared constants for the sleep-mode port clock gating block
package spcg_pkg;
	localparam int ADDR_W = 12;
	localparam int PORT_N = 8;
	localparam logic [31:0] SYSCTL_BASE = 32'h400fe000;
	localparam logic [11:0] SLEEP_GATE_OFF = 12'h118;
	localparam logic [11:0] RUN_GATE_OFF = 12'h108;
	localparam logic [11:0] DEEP_GATE_OFF = 12'h128;
	localparam logic [11:0] RUN_CFG_OFF = 12'h060;
	localparam logic [11:0] IRQ_STAT_OFF = 12'h800;
	localparam logic [11:0] IRQ_MASK_OFF = 12'h804;
	localparam logic [11:0] PWR_STATE_OFF = 12'h808;
	localparam int AUTO_GATE_BIT = 27;
	localparam logic [7:0] GATE_RESET = 8'h00;
	localparam logic [31:0] RUN_CFG_RESET = 32'h00000000;
	localparam int IRQ_FAULT_BIT = 0;
	localparam int IRQ_CHANGE_BIT = 1;
	localparam int IRQ_W = 2;
	typedef enum logic [2:0] {
		SPCG_RUN = 3'b001,
		SPCG_SLEEP = 3'b010,
		SPCG_DEEP = 3'b100
	} spcg_pwr_e;
endpackage

// File: tb/spcg_props.sv
// Port-level checker for the sleep port clock gate
`timescale 1ns/1ps
module spcg_props (
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Reset, low
	input wire logic [11:0] reg_addr, // Offset
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic irq, // Interrupt
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic [1:0] pwr_state, // Power state
	input wire logic port_acc, // Port access
	input wire logic [2:0] port_sel, // Port index
	input wire logic port_fault, // Fault pulse
	input wire logic [7:0] port_clk_en // Enables
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_fault_gated: assert property (port_acc && !port_clk_en[port_sel] |=> port_fault)
		else $error("no fault on gated port");
	a_fault_cause: assert property (port_fault |-> $past(port_acc) && !$past(port_clk_en[port_sel]))
		else $error("fault without gated access");
	a_gate_upper: assert property (reg_rd && reg_addr == spcg_pkg::SLEEP_GATE_OFF |=> reg_rdata[31:8] == 24'h000000)
		else $error("reserved bits not zero");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 12'h004 |=> reg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	// Enables move only two edges after a write or three after a state change
	a_en_cause: assert property ($changed(port_clk_en) |-> $past(reg_wr, 2) || $past(pwr_state, 3) != $past(pwr_state, 4))
		else $error("enable changed without cause");
	a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> port_clk_en == 8'h00 && !port_fault)
		else $error("outputs not cleared by reset");
	a_irq_masked: assert property (reg_wr && reg_addr == spcg_pkg::IRQ_MASK_OFF && reg_wdata[1:0] == 2'h0 |=> !irq)
		else $error("irq high with all masked");
endmodule // spcg_props
bind spcg_gate spcg_props u_props (.*);

// File: tb/tb_top.sv
// Directed bench for the sleep port clock gate
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, rst_n, reg_wr, reg_rd, port_acc, port_fault, irq;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [1:0] pwr_state;
	logic [2:0] port_sel;
	logic [7:0] port_clk_en;
	int n_fail, compares;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
	$display("mismatch %0t got %h want %h", $time, a, e); end end
	spcg_gate dut (.*);
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		`CHK(reg_rdata, e)
	endtask
	task acc(input logic [2:0] p, input logic e);
		@(posedge ref_clk);
		port_sel <= p;
		port_acc <= 1'b1;
		@(posedge ref_clk);
		port_acc <= 1'b0;
		@(negedge ref_clk);
		`CHK(port_fault, e)
	endtask
	task give_verdict;
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Tests take about 52 cycles; the 1000-cycle limit allows about nineteen times that
	initial begin
		#20000;
		n_fail++;
		give_verdict;
	end
	initial begin
		rst_n = 0; reg_wr = 0; reg_rd = 0; port_acc = 0; port_sel = 0;
		reg_addr = 0; reg_wdata = 0; pwr_state = 0; n_fail = 0; compares = 0;
		tick(5);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		`CHK(port_clk_en, 8'h00)
		rdc(spcg_pkg::SLEEP_GATE_OFF, 32'h0);
		wr(spcg_pkg::RUN_GATE_OFF, 32'hffffff05);
		tick(1);
		@(negedge ref_clk);
		`CHK(port_clk_en, 8'h05)
		rdc(spcg_pkg::RUN_GATE_OFF, 32'h05);
		// Software merges its new bit into the value it read back
		wr(spcg_pkg::RUN_GATE_OFF, 32'h00000005 | 32'h00000008);
		tick(1);
		@(negedge ref_clk);
		`CHK(port_clk_en, 8'h0d)
		wr(spcg_pkg::IRQ_MASK_OFF, 32'h0);
		acc(3'h0, 1'b0);
		acc(3'h1, 1'b1);
		acc(3'h3, 1'b0);
		`CHK(irq, 1'b0)
		wr(spcg_pkg::IRQ_MASK_OFF, 32'h1);
		@(negedge ref_clk);
		`CHK(irq, 1'b1)
		wr(spcg_pkg::IRQ_STAT_OFF, 32'h3);
		@(negedge ref_clk);
		`CHK(irq, 1'b0)
		// Sleep without auto gating keeps the run values
		wr(spcg_pkg::SLEEP_GATE_OFF, 32'hffffffa0);
		pwr_state <= 2'h1;
		tick(4);
		@(negedge ref_clk);
		`CHK(port_clk_en, 8'h0d)
		wr(spcg_pkg::RUN_CFG_OFF, 32'h08000000);
		tick(1);
		@(negedge ref_clk);
		`CHK(port_clk_en, 8'ha0)
		rdc(spcg_pkg::SLEEP_GATE_OFF, 32'ha0);
		rdc(12'h004, 32'h0);
		wr(spcg_pkg::DEEP_GATE_OFF, 32'h11);
		pwr_state <= 2'h2;
		tick(4);
		@(negedge ref_clk);
		`CHK(port_clk_en, 8'h11)
		tick(1);
		rst_n <= 1'b0;
		tick(2);
		@(negedge ref_clk);
		`CHK(port_clk_en, 8'h00)
		`CHK(irq, 1'b0)
		tick(1);
		rst_n <= 1'b1;
		rdc(spcg_pkg::SLEEP_GATE_OFF, 32'h0);
		give_verdict;
	end
endmodule // tb_top
